/* fol_pkg.sv */
package fol_pkg;
   // ------------------------------------------------------------
   // widths and depth
   // ------------------------------------------------------------
   localparam int FOL_DW = 18;
   localparam int FOL_AW = 13;
   localparam int FOL_DEPTH_WORDS = 8192;
   localparam logic [13:0] FOL_DEPTH = 14'h2000;
   localparam logic [13:0] FOL_HALF = 14'h1000;
   localparam logic [13:0] FOL_ZERO_WORDS = 14'h0000;

   // ------------------------------------------------------------
   // offsets and reset values
   // ------------------------------------------------------------
   localparam logic [12:0] FOL_OFF_PAR_DEFAULT = 13'h007F;
   localparam logic [12:0] FOL_OFF_SER_DEFAULT = 13'h03FF;
   localparam logic FOL_SEL_EMPTY_OFF = 1'b0;
   localparam logic FOL_SEL_FULL_OFF = 1'b1;
   localparam logic [17:0] FOL_DOUT_RESET = 18'h0_0000;

   // ------------------------------------------------------------
   // host command set and sequencer states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      FOL_CMD_WRITE = 3'h0,
      FOL_CMD_READ = 3'h1,
      FOL_CMD_LOAD_OFF = 3'h2,
      FOL_CMD_READ_OFF = 3'h3,
      FOL_CMD_RETRANSMIT = 3'h4,
      FOL_CMD_MASTER_RST = 3'h5,
      FOL_CMD_PARTIAL_RST = 3'h6,
      FOL_CMD_NOP = 3'h7
   } fol_cmd_t;

   typedef enum logic [2:0] {
      FOL_H_IDLE = 3'b001,
      FOL_H_DRIVE = 3'b010,
      FOL_H_CAPTURE = 3'b100
   } fol_hstate_t;

   // ------------------------------------------------------------
   // device and host state
   // ------------------------------------------------------------
   typedef struct packed {
      logic fallThrough;
      logic parallelSel;
      logic [12:0] emptyOff;
      logic [12:0] fullOff;
      logic wrOffPtr;
      logic rdOffPtr;
      logic [12:0] wrPtr;
      logic [12:0] rdPtr;
      logic [13:0] words;
      logic outValid;
      logic rtSetup;
      logic [17:0] dataOut;
      logic emptyN;
      logic fullN;
      logic halfN;
      logic paeStageN;
      logic paeN;
      logic pafStageN;
      logic pafN;
   } fol_dev_t;

   typedef struct packed {
      fol_hstate_t st;
      fol_cmd_t cmd;
      logic [17:0] data;
      logic masterResetN;
      logic partialResetN;
      logic loadSelectN;
      logic writeEnableN;
      logic readEnableN;
      logic retransmitN;
      logic fallThroughMode;
      logic [17:0] dataIn;
      logic rspValid;
      logic [17:0] rspData;
   } fol_host_t;
endpackage

/* fol_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface fol_if;
   logic masterResetN;
   logic partialResetN;
   logic fallThroughMode;
   logic loadSelectN;
   logic writeEnableN;
   logic readEnableN;
   logic retransmitN;
   logic [17:0] dataIn;
   logic [17:0] dataOut;
   logic emptyOrReadyN;
   logic fullOrInReadyN;
   logic halfFullN;
   logic almostEmptyN;
   logic almostFullN;

   modport dev (
      input masterResetN, partialResetN, fallThroughMode, loadSelectN,
      input writeEnableN, readEnableN, retransmitN, dataIn,
      output dataOut, emptyOrReadyN, fullOrInReadyN, halfFullN,
      output almostEmptyN, almostFullN
   );
   modport host (
      output masterResetN, partialResetN, fallThroughMode, loadSelectN,
      output writeEnableN, readEnableN, retransmitN, dataIn,
      input dataOut, emptyOrReadyN, fullOrInReadyN, halfFullN,
      input almostEmptyN, almostFullN
   );
endinterface
`default_nettype wire

/* fol_device.sv */
`timescale 1ns/1ns
`default_nettype none
module fol_device
   import fol_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // pins
   fol_if.dev pin
);
   fol_dev_t s_q;
   fol_dev_t s_d;
   logic [17:0] mem [FOL_DEPTH_WORDS];
   logic memWr;
   logic [13:0] occ;
   logic [13:0] occNext;
   logic [13:0] fill;
   logic [13:0] paeLimit;
   logic [13:0] pafLimit;
   logic [12:0] offWord;

   // ------------------------------------------------------------
   // memory array
   // ------------------------------------------------------------
   // kept out of the state struct, so reset need not clear every word
   always_ff @(posedge clk) begin
      if (memWr) begin
         mem[s_q.wrPtr] <= pin.dataIn;
      end
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      memWr = 1'b0;
      occ = FOL_ZERO_WORDS;
      occNext = FOL_ZERO_WORDS;
      fill = FOL_ZERO_WORDS;
      paeLimit = FOL_ZERO_WORDS;
      pafLimit = FOL_ZERO_WORDS;
      offWord = FOL_OFF_PAR_DEFAULT;
      s_d.rtSetup = 1'b0;
      if (!pin.masterResetN) begin
         s_d.fallThrough = pin.fallThroughMode;
         s_d.parallelSel = !pin.loadSelectN;
         s_d.emptyOff = pin.loadSelectN ? FOL_OFF_SER_DEFAULT : FOL_OFF_PAR_DEFAULT;
         s_d.fullOff = pin.loadSelectN ? FOL_OFF_SER_DEFAULT : FOL_OFF_PAR_DEFAULT;
         s_d.wrOffPtr = FOL_SEL_EMPTY_OFF;
         s_d.rdOffPtr = FOL_SEL_EMPTY_OFF;
         s_d.wrPtr = '0;
         s_d.rdPtr = '0;
         s_d.words = FOL_ZERO_WORDS;
         s_d.outValid = 1'b0;
         s_d.dataOut = FOL_DOUT_RESET;
      end else if (!pin.partialResetN) begin
         // offsets, offset pointers and both latched modes stay put
         s_d.wrPtr = '0;
         s_d.rdPtr = '0;
         s_d.words = FOL_ZERO_WORDS;
         s_d.outValid = 1'b0;
         s_d.dataOut = FOL_DOUT_RESET;
      end else if (!pin.retransmitN) begin
         // enables are high by contract, so no transfer competes
         s_d.rdPtr = '0;
         s_d.words = {1'b0, s_q.wrPtr};
         s_d.outValid = 1'b0;
         s_d.rtSetup = 1'b1;
      end else begin
         // ---------------------------------------------------
         // write side
         // ---------------------------------------------------
         if (!pin.writeEnableN) begin
            if (!pin.loadSelectN) begin
               if (s_q.parallelSel) begin
                  if (s_q.wrOffPtr == FOL_SEL_EMPTY_OFF) begin
                     s_d.emptyOff = pin.dataIn[12:0];
                  end else begin
                     s_d.fullOff = pin.dataIn[12:0];
                  end
                  s_d.wrOffPtr = !s_q.wrOffPtr;
               end
            end else if (s_q.fullN ^ s_q.fallThrough) begin
               memWr = 1'b1;
               s_d.wrPtr = s_q.wrPtr + 13'h0001;
               s_d.words = s_d.words + 14'h0001;
            end
         end
         // ---------------------------------------------------
         // read side
         // ---------------------------------------------------
         if (!pin.readEnableN && !pin.loadSelectN) begin
            // readback replaces any memory word on the output
            offWord = (s_q.rdOffPtr == FOL_SEL_EMPTY_OFF) ? s_q.emptyOff : s_q.fullOff;
            s_d.dataOut = {5'h00, offWord};
            s_d.rdOffPtr = !s_q.rdOffPtr;
         end else if (!s_q.fallThrough) begin
            if (!pin.readEnableN && s_q.words != FOL_ZERO_WORDS) begin
               s_d.dataOut = mem[s_q.rdPtr];
               s_d.rdPtr = s_q.rdPtr + 13'h0001;
               s_d.words = s_d.words - 14'h0001;
            end
         end else if ((!s_q.outValid || !pin.readEnableN) && s_q.words != FOL_ZERO_WORDS) begin
            // first word falls through with no enable, later ones need it
            s_d.dataOut = mem[s_q.rdPtr];
            s_d.rdPtr = s_q.rdPtr + 13'h0001;
            s_d.words = s_d.words - 14'h0001;
            s_d.outValid = 1'b1;
         end else if (!pin.readEnableN) begin
            s_d.outValid = 1'b0;
         end
      end

      // ------------------------------------------------------------
      // flags
      // ------------------------------------------------------------
      occ = s_q.words + {13'h0000, s_q.outValid};
      occNext = s_d.words + {13'h0000, s_d.outValid};
      if (s_d.fallThrough) begin
         s_d.emptyN = !s_d.outValid;
         s_d.fullN = (occNext == FOL_DEPTH + 14'h0001);
         s_d.halfN = !(occNext > FOL_HALF + 14'h0001);
      end else begin
         s_d.emptyN = (s_d.words != FOL_ZERO_WORDS) && !s_d.rtSetup;
         s_d.fullN = (s_d.words != FOL_DEPTH);
         s_d.halfN = !(s_d.words > FOL_HALF);
      end
      // two-stage pipes: a new offset or a retransmit shows on the
      // second edge, the figure the host relies on
      // the output register holds a word in fall-through timing, so both
      // thresholds sit one word higher there
      if (s_q.fallThrough) begin
         fill = occ;
         paeLimit = {1'b0, s_q.emptyOff} + 14'h0001;
         pafLimit = FOL_DEPTH + 14'h0001 - {1'b0, s_q.fullOff};
      end else begin
         fill = s_q.words;
         paeLimit = {1'b0, s_q.emptyOff};
         pafLimit = FOL_DEPTH - {1'b0, s_q.fullOff};
      end
      s_d.paeStageN = !(fill <= paeLimit);
      s_d.pafStageN = !(fill >= pafLimit);
      s_d.paeN = s_q.paeStageN;
      s_d.pafN = s_q.pafStageN;
      if (!pin.masterResetN || !pin.partialResetN) begin
         s_d.paeStageN = 1'b0;
         s_d.paeN = 1'b0;
         s_d.pafStageN = 1'b1;
         s_d.pafN = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
         s_q.emptyOff <= FOL_OFF_PAR_DEFAULT;
         s_q.fullOff <= FOL_OFF_PAR_DEFAULT;
         s_q.parallelSel <= 1'b1;
         s_q.fullN <= 1'b1;
         s_q.halfN <= 1'b1;
         s_q.pafStageN <= 1'b1;
         s_q.pafN <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // outputs come straight from the state register
   // ------------------------------------------------------------
   assign pin.dataOut = s_q.dataOut;
   assign pin.emptyOrReadyN = s_q.emptyN;
   assign pin.fullOrInReadyN = s_q.fullN;
   assign pin.halfFullN = s_q.halfN;
   assign pin.almostEmptyN = s_q.paeN;
   assign pin.almostFullN = s_q.pafN;
endmodule
`default_nettype wire

/* fol_host.sv */
`timescale 1ns/1ns
`default_nettype none
module fol_host
   import fol_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // user command
   input wire logic cmdValid,
   input wire fol_cmd_t cmdKind,
   input wire logic [17:0] cmdData,
   output logic cmdReady,
   // user answer
   output logic rspValid,
   output logic [17:0] rspData,
   // pins
   fol_if.host pin
);
   fol_host_t h_q;
   fol_host_t h_d;

   // ------------------------------------------------------------
   // command sequencer
   // ------------------------------------------------------------
   // one command at a time, so an offset read never meets an
   // offset write
   always_comb begin
      h_d = h_q;
      h_d.rspValid = 1'b0;
      h_d.masterResetN = 1'b1;
      h_d.partialResetN = 1'b1;
      h_d.loadSelectN = 1'b1;
      h_d.writeEnableN = 1'b1;
      h_d.readEnableN = 1'b1;
      h_d.retransmitN = 1'b1;
      unique case (h_q.st)
         FOL_H_IDLE: begin
            if (cmdValid) begin
               h_d.cmd = cmdKind;
               h_d.data = cmdData;
               h_d.st = FOL_H_DRIVE;
               h_d.dataIn = cmdData;
               unique case (cmdKind)
                  FOL_CMD_WRITE: h_d.writeEnableN = 1'b0;
                  FOL_CMD_READ: h_d.readEnableN = 1'b0;
                  FOL_CMD_LOAD_OFF: begin
                     h_d.loadSelectN = 1'b0;
                     h_d.writeEnableN = 1'b0;
                  end
                  FOL_CMD_READ_OFF: begin
                     h_d.loadSelectN = 1'b0;
                     h_d.readEnableN = 1'b0;
                  end
                  FOL_CMD_RETRANSMIT: h_d.retransmitN = 1'b0;
                  FOL_CMD_MASTER_RST: begin
                     // bit 0 picks fall-through, bit 1 picks serial method
                     h_d.masterResetN = 1'b0;
                     h_d.fallThroughMode = cmdData[0];
                     h_d.loadSelectN = cmdData[1];
                  end
                  FOL_CMD_PARTIAL_RST: h_d.partialResetN = 1'b0;
                  FOL_CMD_NOP: h_d.st = FOL_H_IDLE;
               endcase
            end
         end
         FOL_H_DRIVE: begin
            h_d.st = FOL_H_CAPTURE;
         end
         FOL_H_CAPTURE: begin
            // data out settled on the edge that took the enable
            h_d.rspValid = (h_q.cmd == FOL_CMD_READ) || (h_q.cmd == FOL_CMD_READ_OFF);
            h_d.rspData = pin.dataOut;
            h_d.st = FOL_H_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         h_q <= '0;
         h_q.st <= FOL_H_IDLE;
         h_q.cmd <= FOL_CMD_NOP;
         h_q.masterResetN <= 1'b0;
         h_q.partialResetN <= 1'b1;
         h_q.loadSelectN <= 1'b0;
         h_q.writeEnableN <= 1'b1;
         h_q.readEnableN <= 1'b1;
         h_q.retransmitN <= 1'b1;
      end else begin
         h_q <= h_d;
      end
   end

   assign cmdReady = (h_q.st == FOL_H_IDLE);
   assign rspValid = h_q.rspValid;
   assign rspData = h_q.rspData;
   assign pin.masterResetN = h_q.masterResetN;
   assign pin.partialResetN = h_q.partialResetN;
   assign pin.fallThroughMode = h_q.fallThroughMode;
   assign pin.loadSelectN = h_q.loadSelectN;
   assign pin.writeEnableN = h_q.writeEnableN;
   assign pin.readEnableN = h_q.readEnableN;
   assign pin.retransmitN = h_q.retransmitN;
   assign pin.dataIn = h_q.dataIn;
endmodule
`default_nettype wire

/* fol_check_props.sv */
`timescale 1ns/1ns
`default_nettype none
module fol_check_props (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // host to device
   input wire logic masterResetN,
   input wire logic partialResetN,
   input wire logic fallThroughMode,
   input wire logic loadSelectN,
   input wire logic writeEnableN,
   input wire logic readEnableN,
   input wire logic retransmitN,
   // device to host
   input wire logic [17:0] dataOut,
   input wire logic emptyOrReadyN,
   input wire logic halfFullN
);
   // ----------------------------------------
   // helper state
   // ----------------------------------------
   logic ftQ;
   logic rtTaken;
   logic offRead;
   // mode copy, so retransmit flags can be judged per timing mode
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ftQ <= 1'b0;
      end else if (!masterResetN) begin
         ftQ <= fallThroughMode;
      end
   end
   assign rtTaken = masterResetN && partialResetN && !retransmitN;
   assign offRead = masterResetN && partialResetN && retransmitN && !loadSelectN && !readEnableN;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // ----------------------------------------
   // properties
   // ----------------------------------------
   property p_mrsMode;
      !masterResetN |=> emptyOrReadyN == $past(fallThroughMode) && halfFullN && dataOut == 18'h0_0000;
   endproperty
   a_mrsMode: assert property (p_mrsMode) else $error("mode flags wrong after master reset");
   property p_rtStdLow;
      rtTaken && !ftQ |=> !emptyOrReadyN;
   endproperty
   a_rtStdLow: assert property (p_rtStdLow) else $error("empty not low at retransmit");
   property p_rtStdDone;
      rtTaken && !ftQ |=> ##1 emptyOrReadyN;
   endproperty
   a_rtStdDone: assert property (p_rtStdDone) else $error("retransmit setup not done");
   property p_rtFtHigh;
      rtTaken && ftQ |=> emptyOrReadyN;
   endproperty
   a_rtFtHigh: assert property (p_rtFtHigh) else $error("ready not high at retransmit");
   property p_rtFtDone;
      rtTaken && ftQ |=> ##1 !emptyOrReadyN;
   endproperty
   a_rtFtDone: assert property (p_rtFtDone) else $error("first word not presented");
   property p_noRdWr;
      !loadSelectN |-> writeEnableN || readEnableN;
   endproperty
   a_noRdWr: assert property (p_noRdWr) else $error("offset read and write together");
   property p_rtQuiet;
      !retransmitN |-> writeEnableN && readEnableN;
   endproperty
   a_rtQuiet: assert property (p_rtQuiet) else $error("retransmit with enable low");
   property p_offUpper;
      offRead |=> dataOut[17:13] == 5'h00;
   endproperty
   a_offUpper: assert property (p_offUpper) else $error("readback upper bits set");
endmodule
`default_nettype wire

/* test_fifo_offset_load_and_retransmit.sv */
`timescale 1ns/1ns
`default_nettype none
module test_fifo_offset_load_and_retransmit;
   import fol_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic cmdValid = 1'b0;
   fol_cmd_t cmdKind = FOL_CMD_NOP;
   logic [17:0] cmdData = 18'h0_0000;
   logic cmdReady;
   logic rspValid;
   logic [17:0] rspData;
   logic [17:0] expQ[$];
   logic [17:0] wq[$];
   logic [15:0] seed = 16'h145D;
   logic [17:0] ld[0:3];
   int err_total = 0;
   int num_checks = 0;

   fol_if pin ();
   fol_device i_fol_device (.clk(clk), .rstn(rstn), .pin(pin));
   fol_host i_fol_host (.clk(clk), .rstn(rstn), .cmdValid(cmdValid), .cmdKind(cmdKind),
      .cmdData(cmdData), .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData), .pin(pin));
   fol_check_props i_fol_check_props (.clk(clk), .rstn(rstn), .masterResetN(pin.masterResetN),
      .partialResetN(pin.partialResetN), .fallThroughMode(pin.fallThroughMode),
      .loadSelectN(pin.loadSelectN), .writeEnableN(pin.writeEnableN),
      .readEnableN(pin.readEnableN), .retransmitN(pin.retransmitN), .dataOut(pin.dataOut),
      .emptyOrReadyN(pin.emptyOrReadyN), .halfFullN(pin.halfFullN));

   always #4 clk = ~clk;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [15:0] nextRand(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic check(string what, logic [17:0] seen, logic [17:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // offer one command; an answered one leaves its expected value in the queue
   task automatic cmd(fol_cmd_t k, logic [17:0] d, logic ans, logic [17:0] e);
      int n;
      n = 0;
      while (cmdReady !== 1'b1 && n < 50) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (cmdReady !== 1'b1) begin
         err_total++;
      end
      cmdValid = 1'b1;
      cmdKind = k;
      cmdData = d;
      if (ans) begin
         expQ.push_back(e);
      end
      @(posedge clk);
      #1;
      cmdValid = 1'b0;
   endtask
   task automatic offRd(logic [17:0] e);
      cmd(FOL_CMD_READ_OFF, 18'h0_0000, 1'b1, e);
   endtask
   task automatic memWr;
      seed = nextRand(seed);
      wq.push_back({seed[1:0], seed});
      cmd(FOL_CMD_WRITE, {seed[1:0], seed}, 1'b0, 18'h0_0000);
   endtask

   // ----------------------------------------
   // answer monitor
   // ----------------------------------------
   // looked at mid-cycle, away from the edge that launches the answer
   always @(negedge clk) begin
      if (rspValid === 1'b1) begin
         if (expQ.size() == 0) begin
            check("unasked answer", rspData, 18'h3_FFFF);
         end else begin
            check("answer", rspData, expQ.pop_front());
         end
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      test_done;
   end

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      #1;
      rstn = 1'b1;
      cmd(FOL_CMD_MASTER_RST, 18'h0_0000, 1'b0, 18'h0_0000);
      offRd(18'h0_007F);
      // loads interleaved with memory writes, pointer wraps after the second, so the third lands on the empty offset
      for (int i = 0; i < 3; i++) begin
         seed = nextRand(seed);
         ld[i] = {5'h00, seed[12:0]};
         cmd(FOL_CMD_LOAD_OFF, {5'h1F, seed[12:0]}, 1'b0, 18'h0_0000);
         memWr();
      end
      // read pointer already sits on the full offset
      offRd(ld[1]);
      cmd(FOL_CMD_READ, 18'h0_0000, 1'b1, wq[0]);
      offRd(ld[2]);
      offRd(ld[1]);
      cmd(FOL_CMD_RETRANSMIT, 18'h0_0000, 1'b0, 18'h0_0000);
      cmd(FOL_CMD_READ, 18'h0_0000, 1'b1, wq[0]);
      cmd(FOL_CMD_READ, 18'h0_0000, 1'b1, wq[1]);
      // master reset homes pointers, partial reset keeps them
      cmd(FOL_CMD_MASTER_RST, 18'h0_0000, 1'b0, 18'h0_0000);
      offRd(18'h0_007F);
      seed = nextRand(seed);
      ld[3] = {5'h00, seed[12:0]};
      cmd(FOL_CMD_LOAD_OFF, ld[3], 1'b0, 18'h0_0000);
      cmd(FOL_CMD_PARTIAL_RST, 18'h0_0000, 1'b0, 18'h0_0000);
      cmd(FOL_CMD_LOAD_OFF, 18'h0_0ABC, 1'b0, 18'h0_0000);
      // read pointer was left on the full offset before the partial reset
      offRd(18'h0_0ABC);
      offRd(ld[3]);
      // serial method: parallel loads are ignored
      cmd(FOL_CMD_MASTER_RST, 18'h0_0002, 1'b0, 18'h0_0000);
      offRd(18'h0_03FF);
      cmd(FOL_CMD_LOAD_OFF, 18'h0_0011, 1'b0, 18'h0_0000);
      offRd(18'h0_03FF);
      // fall-through mode readback and retransmit
      cmd(FOL_CMD_MASTER_RST, 18'h0_0001, 1'b0, 18'h0_0000);
      wq.delete();
      memWr();
      memWr();
      offRd(18'h0_007F);
      cmd(FOL_CMD_RETRANSMIT, 18'h0_0000, 1'b0, 18'h0_0000);
      // first word fell through unasked, so an enabled read brings the second
      cmd(FOL_CMD_READ, 18'h0_0000, 1'b1, wq[1]);
      for (int n = 0; n < 50 && expQ.size() > 0; n++) begin
         @(posedge clk);
      end
      repeat (5) @(posedge clk);
      check("pending answers", 18'(expQ.size()), 18'h0_0000);
      test_done;
   end
endmodule
`default_nettype wire
